// ===== dpfs_pkg.sv
package dpfs_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFS_SELECT = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_ERRCNT = 12'h008;
   localparam logic [11:0] OFS_HISTORY = 12'h00C;
   localparam logic [11:0] OFS_SAVED = 12'h010;
   // Field positions of the selection register.
   localparam int SEL_OUTLOSS_BIT = 0;
   localparam int SEL_INLOSS_BIT = 1;
   localparam int SEL_EARTH_BIT = 2;
   localparam int SEL_USERGRP_BIT = 3;
   // Reset values of the selections.
   localparam logic RST_OUTLOSS = 1'b1;
   localparam logic RST_INLOSS = 1'b1;
   localparam logic RST_EARTH = 1'b0;
   localparam logic RST_USERGRP = 1'b0;
   // Fault codes.
   localparam logic [3:0] FC_NONE = 4'h0;
   localparam logic [3:0] FC_OUTPUT_PHASE_LOSS = 4'h1;
   localparam logic [3:0] FC_INPUT_PHASE_LOSS = 4'h2;
   localparam logic [3:0] FC_EARTH_FAULT_OC = 4'h3;
   localparam logic [3:0] FC_LINK_LINE_ERROR = 4'h4;
   localparam logic [3:0] FC_LINK_CIRCUIT = 4'h5;
   // Timing, clock at 200 MHz.
   localparam longint CLK_HZ = 200000000;
   localparam longint INLOSS_TIME_MS = 1000;
   localparam longint EARTH_TIME_MS = 20;
   localparam longint SAVE_TIME_S = 3600;
   localparam longint INLOSS_CYCLES = INLOSS_TIME_MS * CLK_HZ / 1000;
   localparam longint EARTH_CYCLES = EARTH_TIME_MS * CLK_HZ / 1000;
   localparam longint SAVE_CYCLES = SAVE_TIME_S * CLK_HZ;
   // Output frequency threshold for the output loss check, in 0.01 Hz.
   localparam logic [15:0] OUTLOSS_MIN_FREQ = 16'h0064;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_EARTH = 3'b001,
      ST_RUN = 3'b010,
      ST_DECEL = 3'b011,
      ST_TRIP = 3'b100
   } dpfs_state_e;
endpackage

// ===== dpfs_timer.sv
`timescale 1ns/1ps
module dpfs_timer import dpfs_pkg::*; #(
   parameter int WIDTH = 40
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Count control.
   input wire logic run,
   input wire logic [WIDTH-1:0] limit,
   // Terminal count reached while run stays high.
   output logic done
);
   logic [WIDTH-1:0] count_ff;

   always_ff @(posedge clk) begin
      if (reset || !run) begin
         count_ff <= '0;
      end else if (count_ff != limit) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign done = run && (count_ff == limit);
endmodule

// ===== dpfs_apb.sv
`timescale 1ns/1ps
module dpfs_apb import dpfs_pkg::*; (
   // APB slave side.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Decoded write strobes and address check.
   output logic wrSelect,
   output logic wrErrCnt,
   output logic addrValid
);
   logic access;

   assign access = psel && penable;
   assign addrValid = (paddr == OFS_SELECT) || (paddr == OFS_STATUS) ||
      (paddr == OFS_ERRCNT) || (paddr == OFS_HISTORY) || (paddr == OFS_SAVED);
   assign wrSelect = access && pwrite && (paddr == OFS_SELECT);
   // Only a write of zero clears the counter; other values are ignored.
   assign wrErrCnt = access && pwrite && (paddr == OFS_ERRCNT) && (pwdata == 32'h0000_0000);
endmodule

// ===== dpfs_supervisor.sv
`timescale 1ns/1ps
// What this block does
// RL1 - Output phase loss select, default enabled.
// RL2 - Output loss trips when running above 1Hz, no braking.
// RL3 - Input loss trips after one continuous second.
// RL4 - Input phase loss select, default enabled.
// RL5 - No input loss check while regenerating.
// RL6 - Earth check only right after start.
// RL7 - Earth check select, default disabled.
// RL8 - Enabled earth check holds output 20ms.
// RL9 - Earth fault found trips with earth code.
// RL10 - Line error increments cumulative counter by one.
// RL11 - Writing zero clears the error counter.
// RL12 - Counter copied to nonvolatile store hourly.
// RL13 - Error counter always readable, ignores group setting.
// RL14 - Link faults in run decelerate, then code and output; at idle they trip at once.
// RL15 - Link stop uses normal deceleration time.
// RL16 - Fault shown on pin and status bit.
// RL17 - History appended when fault output asserts.
// RL18 - Link fault stays latched until reset.
module dpfs_supervisor import dpfs_pkg::*; #(
   parameter longint INLOSS_LIMIT = INLOSS_CYCLES,
   parameter longint EARTH_LIMIT = EARTH_CYCLES,
   parameter longint SAVE_LIMIT = SAVE_CYCLES,
   parameter int CNT_WIDTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // APB register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Run control and power stage sensing.
   input wire logic startCmd,
   input wire logic dcBraking,
   input wire logic regenerating,
   input wire logic [15:0] outFreq,
   input wire logic outPhaseLost,
   input wire logic inPhaseLost,
   input wire logic earthFaultSense,
   input wire logic decelDone,
   // Remote link status.
   input wire logic linkLineError,
   input wire logic linkCircuitFault,
   // Nonvolatile store, value loaded after power-on.
   input wire logic [CNT_WIDTH-1:0] nvSavedCount,
   output logic nvWrite,
   output logic [CNT_WIDTH-1:0] nvWriteData,
   // Drive outputs.
   output logic outputEnable,
   output logic decelRequest,
   output logic fault_output_signal,
   output logic [3:0] faultCode,
   output logic historyWrite
);
   dpfs_state_e state_ff;
   dpfs_state_e nxt_state;
   logic outLossSel_ff, inLossSel_ff, earthSel_ff, userGrp_ff;
   logic [CNT_WIDTH-1:0] errCnt_ff;
   logic loaded_ff;
   logic lineErrD_ff;
   logic [3:0] pendCode_ff;
   logic [3:0] lastCode_ff;
   logic wrSelect, wrErrCnt, addrValid;
   logic inLossDone, earthDone, saveDone, saveDone_ff;
   logic lineErrEdge, linkFault;
   logic outLossTrip, inLossTrip;
   logic [3:0] nxt_code;

   dpfs_apb u_apb (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .wrSelect(wrSelect),
      .wrErrCnt(wrErrCnt),
      .addrValid(addrValid)
   );

   // Regeneration breaks the continuous-loss window as well as gating it.
   dpfs_timer #(.WIDTH(40)) u_inloss (
      .clk(clk),
      .reset(reset),
      .run(inLossSel_ff && inPhaseLost && !regenerating && state_ff == ST_RUN), // [RL3] [RL5]
      .limit(40'(INLOSS_LIMIT)),
      .done(inLossDone)
   );

   dpfs_timer #(.WIDTH(40)) u_earth (
      .clk(clk),
      .reset(reset),
      .run(state_ff == ST_EARTH), // [RL8]
      .limit(40'(EARTH_LIMIT)),
      .done(earthDone)
   );

   dpfs_timer #(.WIDTH(40)) u_save (
      .clk(clk),
      .reset(reset),
      .run(!saveDone_ff), // [RL12]
      .limit(40'(SAVE_LIMIT)),
      .done(saveDone)
   );
   always_ff @(posedge clk) begin
      saveDone_ff <= reset ? 1'b0 : saveDone;
   end

   assign lineErrEdge = linkLineError && !lineErrD_ff;
   assign linkFault = linkLineError || linkCircuitFault;
   assign outLossTrip = outLossSel_ff && outPhaseLost && !dcBraking &&
      (outFreq > OUTLOSS_MIN_FREQ); // [RL1] [RL2]
   assign inLossTrip = inLossDone; // [RL3]

   // Selection register.
   always_ff @(posedge clk) begin
      if (reset) begin
         outLossSel_ff <= RST_OUTLOSS; // [RL1]
         inLossSel_ff <= RST_INLOSS; // [RL4]
         earthSel_ff <= RST_EARTH; // [RL7]
         userGrp_ff <= RST_USERGRP;
      end else if (wrSelect) begin
         outLossSel_ff <= pwdata[SEL_OUTLOSS_BIT];
         inLossSel_ff <= pwdata[SEL_INLOSS_BIT];
         earthSel_ff <= pwdata[SEL_EARTH_BIT];
         userGrp_ff <= pwdata[SEL_USERGRP_BIT];
      end
   end

   // Error counter; a new error with a same-cycle clear leaves the count at one.
   always_ff @(posedge clk) begin
      lineErrD_ff <= reset ? 1'b0 : linkLineError;
      if (reset) begin
         errCnt_ff <= '0;
         loaded_ff <= 1'b0;
      end else if (!loaded_ff) begin
         errCnt_ff <= nvSavedCount; // [RL12]
         loaded_ff <= 1'b1;
      end else if (lineErrEdge) begin
         errCnt_ff <= wrErrCnt ? CNT_WIDTH'(1) : errCnt_ff + 1'b1; // [RL10]
      end else if (wrErrCnt) begin
         errCnt_ff <= '0; // [RL11]
      end
   end

   // Hourly save to the nonvolatile store.
   always_ff @(posedge clk) begin
      if (reset) begin
         nvWrite <= 1'b0;
         nvWriteData <= '0;
      end else begin
         nvWrite <= saveDone; // [RL12]
         if (saveDone) begin
            nvWriteData <= errCnt_ff;
         end
      end
   end

   // Sequencer.
   always_comb begin
      nxt_state = state_ff;
      nxt_code = pendCode_ff;
      case (state_ff)
         ST_IDLE: begin
            if (linkFault) begin
               nxt_state = ST_TRIP;
               nxt_code = linkLineError ? FC_LINK_LINE_ERROR : FC_LINK_CIRCUIT;
            end else if (startCmd) begin
               nxt_state = earthSel_ff ? ST_EARTH : ST_RUN; // [RL6] [RL8]
            end
         end
         ST_EARTH: begin
            if (earthSel_ff && earthFaultSense) begin
               nxt_state = ST_TRIP;
               nxt_code = FC_EARTH_FAULT_OC; // [RL9]
            end else if (earthDone) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (linkFault) begin
               nxt_state = ST_DECEL; // [RL14] [RL15]
               nxt_code = linkLineError ? FC_LINK_LINE_ERROR : FC_LINK_CIRCUIT;
            end else if (outLossTrip) begin
               nxt_state = ST_TRIP;
               nxt_code = FC_OUTPUT_PHASE_LOSS; // [RL2]
            end else if (inLossTrip) begin
               nxt_state = ST_TRIP;
               nxt_code = FC_INPUT_PHASE_LOSS; // [RL3]
            end else if (!startCmd) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_DECEL: begin
            if (decelDone) begin
               nxt_state = ST_TRIP; // [RL14]
            end
         end
         ST_TRIP: nxt_state = ST_TRIP; // [RL18]
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         pendCode_ff <= FC_NONE;
      end else begin
         state_ff <= nxt_state;
         pendCode_ff <= nxt_code;
      end
   end

   // Drive outputs, all registered.
   always_ff @(posedge clk) begin
      if (reset) begin
         outputEnable <= 1'b0;
         decelRequest <= 1'b0;
         fault_output_signal <= 1'b0;
         faultCode <= FC_NONE;
         historyWrite <= 1'b0;
         lastCode_ff <= FC_NONE;
      end else begin
         outputEnable <= (nxt_state == ST_RUN) || (nxt_state == ST_DECEL); // [RL8]
         decelRequest <= (nxt_state == ST_DECEL); // [RL15]
         fault_output_signal <= (nxt_state == ST_TRIP); // [RL14] [RL16]
         faultCode <= (nxt_state == ST_TRIP) ? nxt_code : FC_NONE; // [RL14] [RL18]
         historyWrite <= (nxt_state == ST_TRIP) && (state_ff != ST_TRIP); // [RL17]
         if (nxt_state == ST_TRIP && state_ff != ST_TRIP) begin
            lastCode_ff <= nxt_code;
         end
      end
   end

   // Answer registered from the setup cycle, so the access cycle needs no wait state.
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addrValid;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_SELECT: prdata <= {28'h0, userGrp_ff, earthSel_ff, inLossSel_ff, outLossSel_ff};
            OFS_STATUS: prdata <= {24'h0, faultCode, 1'b0, state_ff[1:0] == 2'b00 ? 1'b0 : 1'b1,
               outputEnable, fault_output_signal}; // [RL16]
            OFS_ERRCNT: prdata <= 32'(errCnt_ff); // [RL13]
            OFS_HISTORY: prdata <= {28'h0, lastCode_ff};
            OFS_SAVED: prdata <= 32'(nvWriteData);
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Assertions.
   trip_latched_a: assert property (@(posedge clk) disable iff (reset)
      fault_output_signal |=> fault_output_signal) // [RL18]
      else $error("Fault output dropped without reset.");
   earth_hold_a: assert property (@(posedge clk) disable iff (reset)
      ($rose(state_ff == ST_EARTH)) |-> !outputEnable [*8]) // [RL8]
      else $error("Output released early during earth check.");
   count_inc_a: assert property (@(posedge clk) disable iff (reset)
      (loaded_ff && lineErrEdge && !wrErrCnt) |=> errCnt_ff == $past(errCnt_ff) + 1'b1) // [RL10]
      else $error("Error counter did not step by one.");
   count_clr_a: assert property (@(posedge clk) disable iff (reset)
      (loaded_ff && wrErrCnt && !lineErrEdge) |=> errCnt_ff == '0) // [RL11]
      else $error("Error counter not cleared.");
   decel_first_a: assert property (@(posedge clk) disable iff (reset)
      (state_ff == ST_RUN && linkFault) |=> decelRequest && !fault_output_signal) // [RL14]
      else $error("Link fault did not decelerate first.");
   history_a: assert property (@(posedge clk) disable iff (reset)
      $rose(fault_output_signal) |-> historyWrite) // [RL17]
      else $error("History not written with fault output.");
   out_loss_a: assert property (@(posedge clk) disable iff (reset)
      (state_ff == ST_RUN && !linkFault && outLossTrip) |=>
      faultCode == FC_OUTPUT_PHASE_LOSS) // [RL2]
      else $error("Output phase loss did not trip.");
   regen_a: assert property (@(posedge clk) disable iff (reset)
      regenerating |=> !inLossDone) // [RL5]
      else $error("Input loss evaluated while regenerating.");
endmodule

// ===== dpfs_link_master.sv
`timescale 1ns/1ps
module dpfs_link_master (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Fault injection from the bench.
   input wire logic breakLine,
   input wire logic breakCircuit,
   // Link status seen by the drive.
   output logic linkLineError,
   output logic linkCircuitFault
);
   // A broken line is reported as a level until healed, so the drive must count edges.
   always_ff @(posedge clk) begin
      if (reset) begin
         linkLineError <= 1'b0;
         linkCircuitFault <= 1'b0;
      end else begin
         linkLineError <= breakLine;
         linkCircuitFault <= breakCircuit;
      end
   end
endmodule

// ===== drive_protection_fault_supervisor_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin failCount++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module drive_protection_fault_supervisor_bench import dpfs_pkg::*; ();
   localparam int INL = 50;
   localparam int EGL = 20;
   localparam int SVL = 200;
   localparam logic [15:0] NVC = 16'h0005;
   logic clk, psel, penable, pwrite, pready, pslverr, rerr, nvWrite;
   logic reset = 1'b1;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic startCmd, dcBraking, regenerating, outPhaseLost, inPhaseLost, earthFaultSense;
   logic decelDone, linkLineError, linkCircuitFault, breakLine, breakCircuit;
   logic [15:0] outFreq, nvWriteData;
   logic outputEnable, decelRequest, fault_output_signal, historyWrite;
   logic [3:0] faultCode;
   int failCount = 0;
   int cmpCount = 0;
   int n;

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   dpfs_supervisor #(.INLOSS_LIMIT(INL), .EARTH_LIMIT(EGL), .SAVE_LIMIT(SVL)) dpfs_supervisor_i (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .startCmd(startCmd), .dcBraking(dcBraking), .regenerating(regenerating),
      .outFreq(outFreq), .outPhaseLost(outPhaseLost), .inPhaseLost(inPhaseLost),
      .earthFaultSense(earthFaultSense), .decelDone(decelDone),
      .linkLineError(linkLineError), .linkCircuitFault(linkCircuitFault),
      .nvSavedCount(NVC), .nvWrite(nvWrite), .nvWriteData(nvWriteData),
      .outputEnable(outputEnable), .decelRequest(decelRequest),
      .fault_output_signal(fault_output_signal), .faultCode(faultCode),
      .historyWrite(historyWrite));

   dpfs_link_master dpfs_link_master_i (.clk(clk), .reset(reset), .breakLine(breakLine),
      .breakCircuit(breakCircuit), .linkLineError(linkLineError),
      .linkCircuitFault(linkCircuitFault));

   task report_and_stop;
      if (failCount == 0 && cmpCount > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task do_reset;
      @(posedge clk);
      reset <= 1'b1;
      {psel, penable, pwrite, startCmd, dcBraking, regenerating} <= '0;
      {outPhaseLost, inPhaseLost, earthFaultSense, decelDone, breakLine, breakCircuit} <= '0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      outFreq <= 16'h0000;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK("read", ex, rdat)
   endtask

   // Settle-time sampling on the falling edge keeps checks clear of the launch edge.
   task wait_code(input logic [3:0] c, input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (faultCode !== c && n < lim);
   endtask

   task run_up(input int lim);
      @(posedge clk);
      startCmd <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (outputEnable !== 1'b1 && n < lim);
      `CHK("outputEnable", 1'b1, outputEnable)
      @(posedge clk);
      outFreq <= 16'h0064;
   endtask

   task t_defaults;
      do_reset;
      rd(OFS_SELECT, 32'h3);
      rd(OFS_ERRCNT, 32'h5);
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK("pslverr", 1'b1, rerr)
      apb(1'b1, OFS_SELECT, 32'hB);
      rd(OFS_SELECT, 32'hB);
      rd(OFS_ERRCNT, 32'h5);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (nvWrite !== 1'b1 && n < SVL + 20);
      `CHK("nvWrite", 1'b1, nvWrite)
      `CHK("nvWriteData", NVC, nvWriteData)
      rd(OFS_SAVED, {16'h0, NVC});
   endtask

   task t_disabled;
      do_reset;
      apb(1'b1, OFS_SELECT, 32'h0);
      run_up(5);
      @(posedge clk);
      {outPhaseLost, inPhaseLost} <= 2'b11;
      outFreq <= 16'h00C8;
      repeat (80) @(negedge clk);
      `CHK("faultCode", FC_NONE, faultCode)
   endtask

   task t_outloss;
      do_reset;
      run_up(5);
      @(posedge clk);
      outPhaseLost <= 1'b1;
      repeat (30) @(posedge clk);
      dcBraking <= 1'b1;
      outFreq <= 16'h0065;
      repeat (30) @(negedge clk);
      `CHK("faultCode", FC_NONE, faultCode)
      @(posedge clk);
      dcBraking <= 1'b0;
      wait_code(FC_OUTPUT_PHASE_LOSS, 10);
      `CHK("faultCode", FC_OUTPUT_PHASE_LOSS, faultCode)
   endtask

   task t_inloss;
      do_reset;
      run_up(5);
      @(posedge clk);
      {inPhaseLost, regenerating} <= 2'b11;
      repeat (80) @(negedge clk);
      `CHK("faultCode", FC_NONE, faultCode)
      @(posedge clk);
      regenerating <= 1'b0;
      repeat (40) @(posedge clk);
      inPhaseLost <= 1'b0;
      @(posedge clk);
      inPhaseLost <= 1'b1;
      wait_code(FC_INPUT_PHASE_LOSS, 80);
      `CHK("faultCode", FC_INPUT_PHASE_LOSS, faultCode)
      `CHK("inlossTime", 1'b1, n >= INL - 2)
   endtask

   task t_earth;
      do_reset;
      apb(1'b1, OFS_SELECT, 32'h7);
      run_up(EGL + 40);
      `CHK("earthHold", 1'b1, n >= EGL)
      @(posedge clk);
      earthFaultSense <= 1'b1;
      repeat (30) @(negedge clk);
      `CHK("faultCode", FC_NONE, faultCode)
      @(posedge clk);
      startCmd <= 1'b0;
      repeat (5) @(posedge clk);
      startCmd <= 1'b1;
      wait_code(FC_EARTH_FAULT_OC, EGL + 40);
      `CHK("faultCode", FC_EARTH_FAULT_OC, faultCode)
   endtask

   task t_link(input logic line, input logic [3:0] code);
      do_reset;
      run_up(5);
      @(posedge clk);
      breakLine <= line;
      breakCircuit <= ~line;
      repeat (6) @(negedge clk);
      `CHK("decelRequest", 1'b1, decelRequest)
      `CHK("earlyFault", 1'b0, fault_output_signal)
      @(posedge clk);
      decelDone <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (historyWrite !== 1'b1 && n < 5);
      `CHK("historyWrite", 1'b1, historyWrite)
      `CHK("faultOut", 1'b1, fault_output_signal)
      `CHK("faultCode", code, faultCode)
      rd(OFS_STATUS, {24'h0, code, 4'h1});
      rd(OFS_HISTORY, {28'h0, code});
      @(posedge clk);
      {breakLine, breakCircuit, decelDone, startCmd} <= '0;
      repeat (10) @(negedge clk);
      `CHK("latchedOut", 1'b1, fault_output_signal)
      `CHK("latchedCode", code, faultCode)
      rd(OFS_ERRCNT, {16'h0, NVC + {15'h0, line}});
      apb(1'b1, OFS_ERRCNT, 32'h3);
      rd(OFS_ERRCNT, {16'h0, NVC + {15'h0, line}});
      apb(1'b1, OFS_ERRCNT, 32'h0);
      rd(OFS_ERRCNT, 32'h0);
   endtask

   initial begin
      #(20000 * 5);
      failCount++;
      report_and_stop;
   end

   initial begin
      do_reset;
      t_defaults;
      t_disabled;
      t_outloss;
      t_inloss;
      t_earth;
      t_link(1'b1, FC_LINK_LINE_ERROR);
      t_link(1'b0, FC_LINK_CIRCUIT);
      report_and_stop;
   end
endmodule
